// *** pkg/crp_pkg.sv ***
// constants, types and register map of the clock, reset and power control
// assumes a single 250 MHz clock domain shared with the bus front end
package crp_pkg;

    localparam logic [7:0] CRP_CMD_SET_NON_USB = 8'he8;
    localparam logic       CRP_SUB_CMD         = 1'b0;
    localparam logic       CRP_SUB_DATA        = 1'b1;

    localparam logic [7:0] CRP_ADDR_CLK   = 8'h08;
    localparam logic [7:0] CRP_ADDR_RST   = 8'h09;
    localparam logic [7:0] CRP_ADDR_IOMUX = 8'h0a;
    localparam logic [7:0] CRP_ADDR_PWR   = 8'h0b;

    localparam logic [7:0] CRP_RESET_VAL  = 8'h00;
    localparam logic [7:0] CRP_CLK_MASK   = 8'hee;
    localparam logic [7:0] CRP_RST_MASK   = 8'hcb;
    localparam logic [7:0] CRP_PWR_MASK   = 8'h2f;

    // clock_gating_control fields
    localparam int CRP_CLK_SRC_BIT  = 7;
    localparam int CRP_CLK_DIV_HI   = 6;
    localparam int CRP_CLK_DIV_LO   = 5;
    localparam int CRP_CLK_DIS48    = 3;
    localparam int CRP_CLK_DISREC   = 2;
    localparam int CRP_CLK_DISADC   = 1;
    // reset_and_pll_control fields
    localparam int CRP_PLL_HI       = 7;
    localparam int CRP_PLL_LO       = 6;
    localparam int CRP_RST_MMU      = 3;
    localparam int CRP_RST_ADIF     = 1;
    localparam int CRP_RST_AGC      = 0;
    // analog_power_control fields
    localparam int CRP_PWR_PLL      = 5;
    localparam int CRP_PWR_ADL      = 3;
    localparam int CRP_PWR_ADR      = 2;
    localparam int CRP_PWR_AGL      = 1;
    localparam int CRP_PWR_AGR      = 0;

    localparam logic [1:0] CRP_ADC_DIV_BY_1 = 2'h0;
    localparam logic [1:0] CRP_ADC_DIV_BY_2 = 2'h1;
    localparam logic [1:0] CRP_ADC_DIV_BY_4 = 2'h2;
    localparam logic [1:0] CRP_ADC_DIV_BY_8 = 2'h3;
    localparam logic [2:0] CRP_DIV_MASK_1   = 3'h0;
    localparam logic [2:0] CRP_DIV_MASK_2   = 3'h1;
    localparam logic [2:0] CRP_DIV_MASK_4   = 3'h3;
    localparam logic [2:0] CRP_DIV_MASK_8   = 3'h7;
    localparam logic [2:0] CRP_DIV_ZERO     = 3'h0;
    localparam logic [2:0] CRP_DIV_ONE      = 3'h1;

    localparam logic [1:0] CRP_SYNTH_FREQ_CODE_0 = 2'h0; // 256 x 44.1 kHz
    localparam logic [1:0] CRP_SYNTH_FREQ_CODE_1 = 2'h1; // 256 x 32 kHz
    localparam logic [1:0] CRP_SYNTH_FREQ_CODE_2 = 2'h2; // 256 x 48 kHz
    localparam logic [1:0] CRP_SYNTH_FREQ_CODE_3 = 2'h3; // 256 x 44.1 kHz

    typedef enum logic [1:0] {
        CRP_LOCKED,
        CRP_WAIT_ADDR,
        CRP_WAIT_DATA
    } crp_phase_e;

    // one byte delivered by the bus front end
    typedef struct packed {
        logic       sub;
        logic [7:0] data;
    } crp_wr_s;

    typedef struct packed {
        logic       adc_src_from_adc;
        logic [1:0] adc_div_code;
        logic       clk48_en;
        logic       rec_clk_en;
        logic       adc_clk_en;
        logic [1:0] synth_freq_code;
        logic       usb_protocol_memory_manager_rst;
        logic       audio_if_rst;
        logic       gain_ctrl_soft_reset;
        logic       pll_power_down;
        logic       left_adc_power_down;
        logic       right_adc_power_down;
        logic       left_gain_power_down;
        logic       right_gain_power_down;
    } crp_ctrl_s;

endpackage

// *** src/crp_top.sv ***
// clock gating, module reset and analog power control register bank
// assumes the bus front end delivers decoded bytes on the same clock
//
// Contract
// - command 0xE8 on subaddress 0 must precede accepted writes on subaddress 1.
// - register 0x0B bits power analog modules down when set.
// - clock control bit 7 picks ADC clock: 1 from ADC, 0 from PLL.
// - clock control bits 6:5 divide ADC clock by 1, 2, 4 or 8.
// - clock control bit 3 set stops the 48 MHz clock.
// - clock control bit 2 set gates off the receiver clock.
// - clock control bit 1 set gates off the ADC clock.
// - reset/PLL bits 7:6 pick PLL frequency; 00 and 11 both 44.1 kHz.
// - reset/PLL bit 3 set resets the USB protocol and memory block.
// - reset/PLL bit 1 set resets the digital audio interface block.
// - reset/PLL bit 0 set resets the gain control logic.
// - register 0x0A is reserved; writes change nothing.
// - power bit 5 set powers off the PLL.
// - power bit 3 set powers off the left ADC.
// - power bit 2 set powers off the right ADC.
// - power bit 1 set powers off the left gain control.
// - power bit 0 set powers off the right gain control.
`timescale 1ns/1ps

module crp_top
    import crp_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       wr_valid,
    input  wire crp_wr_s    wr_byte,
    input  wire logic       bus_stop,
    input  wire logic       rd_req,
    output logic [7:0]      rd_data,
    output logic            rd_valid,
    output logic            write_armed,
    output crp_ctrl_s       ctrl,
    output logic            adc_div_tick
);

    crp_phase_e phase_q;
    crp_phase_e phase_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic [7:0] clk_q;
    logic [7:0] rst_q;
    logic [7:0] pwr_q;
    logic [7:0] rd_data_q;
    logic       rd_valid_q;
    logic [2:0] div_cnt_q;

    // byte classification
    wire logic cmd_byte  = wr_valid && (wr_byte.sub == CRP_SUB_CMD);
    wire logic data_byte = wr_valid && (wr_byte.sub == CRP_SUB_DATA);
    wire logic arm_cmd   = cmd_byte && (wr_byte.data == CRP_CMD_SET_NON_USB);
    wire logic reg_write = data_byte && (phase_q == CRP_WAIT_DATA);

    wire logic sel_clk = ptr_q == CRP_ADDR_CLK;
    wire logic sel_rst = ptr_q == CRP_ADDR_RST;
    wire logic sel_pwr = ptr_q == CRP_ADDR_PWR;
    // io mux register has no storage at all, so a write cannot leak anywhere
    wire logic [7:0] rd_mux = sel_clk ? clk_q :
                              sel_rst ? rst_q :
                              sel_pwr ? pwr_q : CRP_RESET_VAL;
    wire logic step_ptr = reg_write || (rd_req && phase_q == CRP_WAIT_DATA);

    // any other command leaves non-usb mode, so stray data bytes are dropped
    always_comb
    begin
        phase_d = phase_q;
        ptr_d   = ptr_q;
        case (phase_q)
            CRP_LOCKED:
            begin
                if (arm_cmd)
                    phase_d = CRP_WAIT_ADDR;
            end
            CRP_WAIT_ADDR:
            begin
                if (data_byte)
                begin
                    ptr_d   = wr_byte.data;
                    phase_d = CRP_WAIT_DATA;
                end
            end
            CRP_WAIT_DATA:
            begin
                if (step_ptr)
                    ptr_d = ptr_q + 8'h01;
                if (bus_stop)
                    phase_d = CRP_WAIT_ADDR;
            end
            default:
                phase_d = CRP_LOCKED;
        endcase
        if (cmd_byte && !arm_cmd)
            phase_d = CRP_LOCKED;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_q <= CRP_LOCKED;
            ptr_q   <= CRP_RESET_VAL;
        end
        else
        begin
            phase_q <= phase_d;
            ptr_q   <= ptr_d;
        end
    end

    // reserved bits are masked on write so they always read zero
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_q <= CRP_RESET_VAL;
            rst_q <= CRP_RESET_VAL;
            pwr_q <= CRP_RESET_VAL;
        end
        else if (reg_write)
        begin
            if (sel_clk)
                clk_q <= wr_byte.data & CRP_CLK_MASK;
            if (sel_rst)
                rst_q <= wr_byte.data & CRP_RST_MASK;
            if (sel_pwr)
                pwr_q <= wr_byte.data & CRP_PWR_MASK;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_q  <= CRP_RESET_VAL;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= rd_req;
            if (rd_req)
                rd_data_q <= rd_mux;
        end
    end

    assign rd_data     = rd_data_q;
    assign rd_valid    = rd_valid_q;
    assign write_armed = phase_q != CRP_LOCKED;

    // control fields come straight from register flops
    assign ctrl.adc_src_from_adc = clk_q[CRP_CLK_SRC_BIT];
    assign ctrl.adc_div_code =
        clk_q[CRP_CLK_DIV_HI:CRP_CLK_DIV_LO];
    assign ctrl.clk48_en   = !clk_q[CRP_CLK_DIS48];
    assign ctrl.rec_clk_en = !clk_q[CRP_CLK_DISREC];
    assign ctrl.adc_clk_en = !clk_q[CRP_CLK_DISADC];
    assign ctrl.synth_freq_code = rst_q[CRP_PLL_HI:CRP_PLL_LO];
    assign ctrl.usb_protocol_memory_manager_rst =
        rst_q[CRP_RST_MMU];
    assign ctrl.audio_if_rst         = rst_q[CRP_RST_ADIF];
    assign ctrl.gain_ctrl_soft_reset = rst_q[CRP_RST_AGC];
    assign ctrl.pll_power_down       = pwr_q[CRP_PWR_PLL];
    assign ctrl.left_adc_power_down  = pwr_q[CRP_PWR_ADL];
    assign ctrl.right_adc_power_down = pwr_q[CRP_PWR_ADR];
    assign ctrl.left_gain_power_down = pwr_q[CRP_PWR_AGL];
    assign ctrl.right_gain_power_down = pwr_q[CRP_PWR_AGR];

    // adc divider as an enable pulse on the main clock; held at zero while
    // the adc clock is gated so it restarts in phase when re-enabled
    logic [2:0] div_mask;
    always_comb
    begin
        case (ctrl.adc_div_code)
            CRP_ADC_DIV_BY_1: div_mask = CRP_DIV_MASK_1;
            CRP_ADC_DIV_BY_2: div_mask = CRP_DIV_MASK_2;
            CRP_ADC_DIV_BY_4: div_mask = CRP_DIV_MASK_4;
            CRP_ADC_DIV_BY_8: div_mask = CRP_DIV_MASK_8;
            default:          div_mask = CRP_DIV_MASK_1;
        endcase
    end

    wire logic div_wrap = (div_cnt_q & div_mask) == div_mask;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            div_cnt_q <= CRP_DIV_ZERO;
        else if (!ctrl.adc_clk_en || div_wrap)
            div_cnt_q <= CRP_DIV_ZERO;
        else
            div_cnt_q <= div_cnt_q + CRP_DIV_ONE;
    end

    assign adc_div_tick = ctrl.adc_clk_en && div_wrap;

endmodule

// *** sim/crp_top_asserts.sv ***
// port assertions for the clock, reset and power control bank
// assumes it is bound to crp_top and sees only its ports
`timescale 1ns/1ps
module crp_top_chk
    import crp_pkg::*;
(
    input wire logic      clock,
    input wire logic      rst_n,
    input wire logic      wr_valid,
    input wire crp_wr_s   wr_byte,
    input wire logic      rd_req,
    input wire logic      rd_valid,
    input wire logic      write_armed,
    input wire crp_ctrl_s ctrl,
    input wire logic      adc_div_tick
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic c3 = ctrl.adc_clk_en && ctrl.adc_div_code == CRP_ADC_DIV_BY_8;
    wire logic c1 = ctrl.adc_clk_en && ctrl.adc_div_code == CRP_ADC_DIV_BY_2;
    wire logic c2 = ctrl.adc_clk_en && ctrl.adc_div_code == CRP_ADC_DIV_BY_4;
    AST_ARM: assert property (wr_valid && !wr_byte.sub &&
        wr_byte.data == CRP_CMD_SET_NON_USB |=> write_armed) else $error("no arm");
    AST_DISARM: assert property (wr_valid && !wr_byte.sub &&
        wr_byte.data != CRP_CMD_SET_NON_USB |=> !write_armed) else $error("armed");
    AST_LOCKED: assert property (!write_armed |=> $stable(ctrl))
        else $error("write while unarmed");
    AST_IDLE: assert property (!wr_valid |=> $stable(ctrl))
        else $error("control moved without a write");
    AST_GATED: assert property (!ctrl.adc_clk_en |-> !adc_div_tick)
        else $error("tick while gated");
    AST_DIV1: assert property ((ctrl.adc_clk_en &&
        ctrl.adc_div_code == CRP_ADC_DIV_BY_1) [*2] |-> adc_div_tick)
        else $error("div 1 missed tick");
    AST_DIV8_GAP: assert property (adc_div_tick && c3 ##1 c3 |->
        !adc_div_tick) else $error("div 8 early tick");
    AST_DIV8_PERIOD: assert property (adc_div_tick && c3 ##1 c3 [*8]
        |-> adc_div_tick) else $error("div 8 missed tick");
    AST_DIV2_PERIOD: assert property (adc_div_tick && c1 ##1 c1 [*2]
        |-> adc_div_tick) else $error("div 2 missed tick");
    AST_DIV4_GAP: assert property (adc_div_tick && c2 ##1 c2 |->
        !adc_div_tick) else $error("div 4 early tick");
    AST_DIV4_PERIOD: assert property (adc_div_tick && c2 ##1 c2 [*4]
        |-> adc_div_tick) else $error("div 4 missed tick");
    AST_READ: assert property (rd_req |=> rd_valid)
        else $error("read not answered");
endmodule
bind crp_top crp_top_chk u_chk (.clock(clock), .rst_n(rst_n),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req),
    .rd_valid(rd_valid), .write_armed(write_armed), .ctrl(ctrl),
    .adc_div_tick(adc_div_tick));

// *** sim/crp_mcu.sv ***
// controller model issuing bytes, stops and reads to the bank
// assumes the bench calls its tasks, one at a time
`timescale 1ns/1ps
module crp_mcu
    import crp_pkg::*;
(
    input wire logic clock,
    output logic     wr_valid,
    output crp_wr_s  wr_byte,
    output logic     bus_stop,
    output logic     rd_req
);
    initial
    begin
        {wr_valid, bus_stop, rd_req, wr_byte} = '0;
    end
    // released data shows the inverse so a stale byte cannot pass
    task automatic put(input logic sub, input logic [7:0] d);
        @(posedge clock);
        wr_valid <= 1'b1;
        wr_byte  <= '{sub, d};
        @(posedge clock);
        wr_valid <= 1'b0;
        wr_byte  <= ~wr_byte;
    endtask
    task automatic arm();
        put(CRP_SUB_CMD, CRP_CMD_SET_NON_USB);
    endtask
    task automatic stop();
        @(posedge clock);
        bus_stop <= 1'b1;
        @(posedge clock);
        bus_stop <= 1'b0;
    endtask
    task automatic read();
        @(posedge clock);
        rd_req <= 1'b1;
        @(posedge clock);
        rd_req <= 1'b0;
    endtask
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the clock, reset and power control bank
// assumes crp_mcu drives the bus side and the checker is bound
`timescale 1ns/1ps
module testbench
    import crp_pkg::*;
;
    logic       clock;
    logic       rst_n;
    logic       wr_valid, bus_stop, rd_req, rd_valid, write_armed, tick;
    crp_wr_s    wr_byte;
    logic [7:0] rd_data;
    crp_ctrl_s  ctrl;
    int         fails, compares, cycles;
    logic [7:0] q[$];
    logic [7:0] d[4];
    crp_top dut (.clock(clock), .rst_n(rst_n), .wr_valid(wr_valid),
        .wr_byte(wr_byte), .bus_stop(bus_stop), .rd_req(rd_req),
        .rd_data(rd_data), .rd_valid(rd_valid), .write_armed(write_armed),
        .ctrl(ctrl), .adc_div_tick(tick));
    crp_mcu mcu (.clock(clock), .wr_valid(wr_valid), .wr_byte(wr_byte),
        .bus_stop(bus_stop), .rd_req(rd_req));
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    function automatic crp_ctrl_s exp_of(logic [7:0] c, r, p);
        return '{c[7], c[6:5], ~c[3], ~c[2], ~c[1], r[7:6], r[3], r[1], r[0],
            p[5], p[3], p[2], p[1], p[0]};
    endfunction
    task automatic check_ctrl(input crp_ctrl_s e);
        compares++;
        if (ctrl !== e)
        begin
            fails++;
            $display("Error at %0t: ctrl %h expected %h", $time, ctrl, e);
        end
    endtask
    task automatic test_done();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fails++;
            $display("Error at %0t: timeout", $time);
            test_done();
        end
        else if (rd_valid === 1'b1)
        begin
            compares++;
            if (q.size() == 0 || rd_data !== q[0])
            begin
                fails++;
                $display("Error at %0t: read %h", $time, rd_data);
            end
            if (q.size() > 0)
                void'(q.pop_front());
        end
    end
    initial
    begin
        rst_n = 1'b0;
        void'($urandom(86));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1 check_ctrl(exp_of(8'h00, 8'h00, 8'h00));
        mcu.put(CRP_SUB_DATA, CRP_ADDR_CLK);
        mcu.put(CRP_SUB_DATA, 8'hff);
        #1 check_ctrl(exp_of(8'h00, 8'h00, 8'h00));
        mcu.arm();
        mcu.put(CRP_SUB_DATA, CRP_ADDR_CLK);
        repeat (4) q.push_back(CRP_RESET_VAL);
        repeat (4) mcu.read();
        for (int i = 0; i < 4; i++)
        begin
            d[0] = (8'($urandom) & 8'h9c) | 8'(i << 5) | 8'((i == 0) << 1);
            d[1] = (8'($urandom) & 8'h3f) | 8'(i << 6);
            d[2] = 8'($urandom);
            d[3] = 8'($urandom);
            mcu.arm();
            // re-arming keeps the data phase, so a stop is needed first
            mcu.stop();
            mcu.put(CRP_SUB_DATA, CRP_ADDR_CLK);
            foreach (d[k]) mcu.put(CRP_SUB_DATA, d[k]);
            repeat (12) @(posedge clock);
            #1 check_ctrl(exp_of(d[0], d[1], d[3]));
            mcu.stop();
            mcu.put(CRP_SUB_DATA, CRP_ADDR_CLK);
            q.push_back(d[0] & CRP_CLK_MASK);
            q.push_back(d[1] & CRP_RST_MASK);
            q.push_back(8'h00);
            q.push_back(d[3] & CRP_PWR_MASK);
            repeat (4) mcu.read();
        end
        mcu.put(CRP_SUB_CMD, 8'h70);
        mcu.put(CRP_SUB_DATA, CRP_ADDR_PWR);
        mcu.put(CRP_SUB_DATA, ~d[3]);
        #1 check_ctrl(exp_of(d[0], d[1], d[3]));
        repeat (4) @(posedge clock);
        test_done();
    end
endmodule
